// >>> hw/dpf_debug_port.sv
`timescale 1ns/1ns
// Contract
// - Reading the device code register always returns a fixed 8-bit identification code.
// - Reading the revision register returns a fixed 8-bit code distinct for each revision.
// - Programming is enabled only after the control register gets the first then second code.
// - Once enabled, the device stays out of normal running until a system reset.
// - Command, address and data bytes all pass through the one command data register.
// - Code 0x03 requests a whole-device erase and 0x08 a single page erase.
// - Code 0x06 requests a block read and 0x07 a block write.
// - The select value chooses which register later data reads and writes reach.
// - These registers are reachable only over the debug link, never from firmware.
// - The link is one host-driven clock line and one two-way data line.
module dpf_debug_port
  import dpf_pkg::*;
#(
  parameter logic [7:0] DEVICE_CODE = 8'h5A,   // Arbitrary identification value
  parameter logic [7:0] REVISION_CODE = 8'h0C  // Arbitrary revision value
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic debug_link_clock,
  input wire logic debugLinkDataIn,
  output logic debugLinkDataOut,
  output logic debugLinkDataOe,
  input wire logic flashDone,
  input wire logic flashReadValid,
  input wire logic [7:0] flashReadData,
  output logic programEnabled,
  output logic coreHalt,
  output dpf_flash_req_t flashReq
);

  // ---------------- Link clock domain ----------------
  dpf_link_state_t linkState;
  logic [1:0] insBits;
  logic insPhase;
  logic [2:0] bitCount;
  logic [7:0] shiftReg;
  logic [7:0] debugRegisterSelect;
  logic [7:0] programUnlockControl;
  logic [7:0] programCommandData;
  logic unlockArmed;
  logic linkEnabled;
  logic wrToggle;
  logic [7:0] wrByte;
  logic [2:0] rdSync;
  logic rdToggle;    // Core-domain flop, declared here because the link side reads it
  logic [7:0] rdHold;
  logic [7:0] readMux;
  logic [7:0] frameByte;
  logic frameDone;

  // Byte being completed by the current write bit, LSB first
  assign frameByte = {debugLinkDataIn, shiftReg[7:1]};
  assign frameDone = (linkState == LINK_WRITE) && (bitCount == LAST_BIT);

  // Read multiplexer, unmapped selects read zero
  always_comb begin
    unique case (debugRegisterSelect)
      SEL_DEVICE_CODE: readMux = DEVICE_CODE;
      SEL_REVISION_CODE: readMux = REVISION_CODE;
      SEL_UNLOCK_CONTROL: readMux = programUnlockControl;
      SEL_COMMAND_DATA: readMux = programCommandData;
      default: readMux = 8'h00;
    endcase
  end

  // Frame sequencer: start bit low, two instruction bits, eight data bits
  always_ff @(posedge debug_link_clock or negedge nrst) begin
    if (!nrst) begin
      linkState <= LINK_IDLE;
      insBits <= 2'h0;
      insPhase <= 1'b0;
      bitCount <= 3'h0;
    end else begin
      unique case (linkState)
        LINK_IDLE: begin
          insPhase <= 1'b0;
          bitCount <= 3'h0;
          if (!debugLinkDataIn) begin
            linkState <= LINK_INS;
          end
        end
        LINK_INS: begin
          insPhase <= 1'b1;
          if (!insPhase) begin
            insBits[0] <= debugLinkDataIn;
          end else begin
            insBits[1] <= debugLinkDataIn;
            linkState <= debugLinkDataIn ? LINK_WRITE : LINK_READ;
            if (dpf_ins_t'({debugLinkDataIn, insBits[0]}) == INS_SELECT_WRITE ||
                dpf_ins_t'({debugLinkDataIn, insBits[0]}) == INS_SELECT_READ) begin
              linkState <= insBits[0] ? LINK_WRITE : LINK_READ;
            end else begin
              linkState <= insBits[0] ? LINK_WRITE : LINK_READ;
            end
          end
        end
        LINK_WRITE, LINK_READ: begin
          bitCount <= bitCount + 3'h1;
          if (bitCount == LAST_BIT) begin
            linkState <= LINK_IDLE;
          end
        end
      endcase
    end
  end

  // Shift register: loads read value after the instruction, shifts LSB first
  always_ff @(posedge debug_link_clock or negedge nrst) begin
    if (!nrst) begin
      shiftReg <= 8'h00;
    end else if (linkState == LINK_INS && insPhase) begin
      shiftReg <= (insBits[0] == 1'b0 && debugLinkDataIn) ? debugRegisterSelect : readMux;
    end else if (linkState == LINK_WRITE) begin
      shiftReg <= frameByte;
    end else if (linkState == LINK_READ) begin
      shiftReg <= {1'b0, shiftReg[7:1]};
    end
  end

  // Data pin is driven only during a read frame
  always_ff @(posedge debug_link_clock or negedge nrst) begin
    if (!nrst) begin
      debugLinkDataOe <= 1'b0;
      debugLinkDataOut <= 1'b0;
    end else if (linkState == LINK_INS && insPhase && !insBits[0]) begin
      debugLinkDataOe <= 1'b1;
      debugLinkDataOut <= debugLinkDataIn ? debugRegisterSelect[0] : readMux[0];
    end else if (linkState == LINK_READ && bitCount != LAST_BIT) begin
      debugLinkDataOe <= 1'b1;
      debugLinkDataOut <= shiftReg[1];
    end else begin
      debugLinkDataOe <= 1'b0;
      debugLinkDataOut <= 1'b0;
    end
  end

  // Register writes at the end of a write frame
  always_ff @(posedge debug_link_clock or negedge nrst) begin
    if (!nrst) begin
      debugRegisterSelect <= SELECT_RESET;
      programUnlockControl <= UNLOCK_CONTROL_RESET;
      unlockArmed <= 1'b0;
      linkEnabled <= 1'b0;
    end else if (frameDone && insBits[1]) begin
      debugRegisterSelect <= frameByte;
    end else if (frameDone && debugRegisterSelect == SEL_UNLOCK_CONTROL) begin
      programUnlockControl <= frameByte;
      // Any other value breaks the pair, so the order is enforced
      unlockArmed <= (frameByte == UNLOCK_FIRST);
      if (unlockArmed && frameByte == UNLOCK_SECOND) begin
        linkEnabled <= 1'b1;
      end
    end
    // Writes to the two identity selects fall through untouched
  end

  // Command data register: host writes, or bytes returned by the flash
  always_ff @(posedge debug_link_clock or negedge nrst) begin
    if (!nrst) begin
      programCommandData <= COMMAND_DATA_RESET;
      wrByte <= 8'h00;
      wrToggle <= 1'b0;
      rdSync <= 3'h0;
    end else begin
      rdSync <= {rdSync[1:0], rdToggle};
      if (frameDone && !insBits[1] && debugRegisterSelect == SEL_COMMAND_DATA &&
          linkEnabled) begin
        programCommandData <= frameByte;
        wrByte <= frameByte;
        wrToggle <= ~wrToggle;
      end else if (rdSync[2] != rdSync[1]) begin
        programCommandData <= rdHold;
      end
    end
  end

  // ---------------- Core clock domain ----------------
  logic [1:0] enSync;
  logic [2:0] wrSync;
  logic operandPhase;
  logic byteArrived;

  // Write byte is written with its toggle, so it is already stable when the toggle lands
  assign byteArrived = wrSync[2] != wrSync[1];

  // Enable level crossing; stays set until the system reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enSync <= 2'b00;
      wrSync <= 3'h0;
    end else begin
      enSync <= {enSync[0], linkEnabled};
      wrSync <= {wrSync[1:0], wrToggle};
    end
  end

  assign programEnabled = enSync[1];
  assign coreHalt = enSync[1];

  // Flash read data returns to the link through a toggle event
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdHold <= 8'h00;
      rdToggle <= 1'b0;
    end else if (flashReadValid) begin
      rdHold <= flashReadData;
      rdToggle <= ~rdToggle;
    end
  end

  // First byte is a command, then operands until the flash reports done; a bad code keeps the command phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      operandPhase <= 1'b0;
      flashReq <= '0;
    end else begin
      flashReq <= '0;
      // Done clears the phase, but a byte landing in the same cycle is still taken as an operand if the phase was open
      if (flashDone) begin
        operandPhase <= 1'b0;
      end
      if (byteArrived && operandPhase) begin
        flashReq.operandValid <= 1'b1;
        flashReq.operand <= wrByte;
      end else if (byteArrived) begin
        flashReq.deviceErase <= (wrByte == CMD_DEVICE_ERASE);
        flashReq.pageErase <= (wrByte == CMD_PAGE_ERASE);
        flashReq.blockRead <= (wrByte == CMD_BLOCK_READ);
        flashReq.blockWrite <= (wrByte == CMD_BLOCK_WRITE);
        flashReq.badCommand <= !(wrByte inside {CMD_DEVICE_ERASE, CMD_PAGE_ERASE,
                                                CMD_BLOCK_READ, CMD_BLOCK_WRITE});
        flashReq.operand <= wrByte;
        operandPhase <= wrByte inside {CMD_DEVICE_ERASE, CMD_PAGE_ERASE,
                                       CMD_BLOCK_READ, CMD_BLOCK_WRITE};
      end
    end
  end

  // No firmware-side port exists for any of these registers
endmodule : dpf_debug_port

// >>> hw/dpf_pkg.sv
package dpf_pkg;
  // Debug register select values
  localparam logic [7:0] SEL_DEVICE_CODE = 8'h00;
  localparam logic [7:0] SEL_REVISION_CODE = 8'h01;
  localparam logic [7:0] SEL_UNLOCK_CONTROL = 8'h02;
  localparam logic [7:0] SEL_COMMAND_DATA = 8'hB4;

  // Values after reset
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_CONTROL_RESET = 8'h00;
  localparam logic [7:0] COMMAND_DATA_RESET = 8'h00;

  // Unlock sequence, first then second
  localparam logic [7:0] UNLOCK_FIRST = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND = 8'h01;

  // Flash command codes
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;

  // Frame layout: one start bit, two instruction bits, eight data bits
  localparam int FRAME_DATA_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Link instructions, first bit received is bit 0
  typedef enum logic [1:0] {
    INS_DATA_READ = 2'b00,
    INS_DATA_WRITE = 2'b01,
    INS_SELECT_READ = 2'b10,
    INS_SELECT_WRITE = 2'b11
  } dpf_ins_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_INS = 2'b01,
    LINK_WRITE = 2'b10,
    LINK_READ = 2'b11
  } dpf_link_state_t;

  // Flash request toward the flash controller, one-cycle pulses
  typedef struct packed {
    logic deviceErase;
    logic pageErase;
    logic blockRead;
    logic blockWrite;
    logic badCommand;
    logic operandValid;
    logic [7:0] operand;
  } dpf_flash_req_t;
endpackage : dpf_pkg

// >>> tb/dpf_debug_port_asserts.sv
`timescale 1ns/1ns
module dpf_debug_port_asserts
  import dpf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic debug_link_clock,
  input wire logic debugLinkDataOe,
  input wire logic programEnabled,
  input wire logic coreHalt,
  input wire dpf_flash_req_t flashReq
);
  // Read data stands for at least seven link cycles; the design drives all eight data slots of a frame
  sequence readBits;
    debugLinkDataOe [*7];
  endsequence
  en_sticky_a: assert property (@(posedge core_clk) disable iff (!nrst)
    programEnabled |=> programEnabled) else $error("enable dropped");
  halt_match_a: assert property (@(posedge core_clk) disable iff (!nrst)
    coreHalt == programEnabled) else $error("halt differs from enable");
  req_onehot_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $onehot0(flashReq[13:8])) else $error("two request kinds at once");
  req_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
    flashReq != '0 |=> flashReq == '0) else $error("request wider than a pulse");
  req_locked_a: assert property (@(posedge core_clk) disable iff (!nrst)
    flashReq != '0 |-> programEnabled) else $error("request while locked");
  // No disable here: the reset state itself is what is checked
  reset_quiet_a: assert property (@(posedge core_clk)
    !nrst |-> !programEnabled && flashReq == '0) else $error("outputs live in reset");
  read_span_a: assert property (@(posedge debug_link_clock) disable iff (!nrst)
    $rose(debugLinkDataOe) |-> readBits) else $error("read drive cut short");
  oe_release_a: assert property (@(posedge debug_link_clock) disable iff (!nrst)
    $fell(debugLinkDataOe) |=> !debugLinkDataOe) else $error("line driven after read");
endmodule : dpf_debug_port_asserts

bind dpf_debug_port dpf_debug_port_asserts chk (.core_clk, .nrst, .debug_link_clock,
  .debugLinkDataOe, .programEnabled, .coreHalt, .flashReq);

// >>> tb/dpf_debug_port_tb.sv
`timescale 1ns/1ns
module dpf_debug_port_tb
  import dpf_pkg::*;
;
  localparam logic [7:0] DEV = 8'h6B; // Arbitrary value
  localparam logic [7:0] REV = 8'h1D; // Arbitrary value
  logic core_clk = 1'b0;
  logic nrst = 1'b1; // Pulled low after time zero so the reset edge is seen
  logic flashDone = 1'b0;
  logic flashReadValid = 1'b0;
  logic [7:0] flashReadData = 8'h00;
  logic linkClk, hostBit, dout, oe, programEnabled, coreHalt;
  dpf_flash_req_t flashReq, seen;
  wire logic lineLvl = oe ? dout : hostBit;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] rd;
  logic [7:0] codes [5] = '{8'h55, 8'h03, 8'h08, 8'h06, 8'h07};
  // Command pulses also carry the command byte in the operand field
  logic [15:0] hits [5] = '{16'h0255, 16'h2003, 16'h1008, 16'h0806, 16'h0407};

  initial forever #4 core_clk = ~core_clk;

  dpf_debug_port #(.DEVICE_CODE(DEV), .REVISION_CODE(REV)) dut (
    .core_clk, .nrst, .debug_link_clock(linkClk), .debugLinkDataIn(lineLvl),
    .debugLinkDataOut(dout), .debugLinkDataOe(oe), .flashDone, .flashReadValid,
    .flashReadData, .programEnabled, .coreHalt, .flashReq);
  dpf_host_model host (.lineLvl, .linkClk, .hostBit);

  // Sticky record of request pulses
  always @(posedge core_clk) seen <= seen | flashReq;

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] sel, input logic [7:0] d);
    @(posedge core_clk) #1;
    host.frame(INS_SELECT_WRITE, sel, rd);
    host.frame(INS_DATA_WRITE, d, rd);
  endtask : wr

  task automatic rdck(input logic [7:0] sel, input logic [7:0] exp);
    @(posedge core_clk) #1;
    host.frame(INS_SELECT_WRITE, sel, rd);
    host.frame(INS_DATA_READ, 8'h00, rd);
    check({8'h00, rd}, {8'h00, exp});
  endtask : rdck

  // Crossing takes a few core cycles, so wait before judging
  task automatic cmd(input logic [7:0] d, input logic [15:0] exp);
    // Clear off the edge, so the recorder's update cannot undo it
    @(posedge core_clk) #1 seen = '0;
    wr(SEL_COMMAND_DATA, d);
    repeat (8) @(posedge core_clk);
    check(seen, exp);
  endtask : cmd

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    #1 nrst = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 nrst = 1'b1;
    check({programEnabled, coreHalt}, 16'h0);
    rdck(SEL_DEVICE_CODE, DEV);
    rdck(SEL_REVISION_CODE, REV);
    rdck(SEL_UNLOCK_CONTROL, UNLOCK_CONTROL_RESET);
    rdck(SEL_COMMAND_DATA, COMMAND_DATA_RESET);
    wr(SEL_DEVICE_CODE, 8'hFF);
    wr(SEL_REVISION_CODE, 8'hFF);
    rdck(SEL_DEVICE_CODE, DEV);
    rdck(SEL_REVISION_CODE, REV);
    rdck(8'h77, 8'h00);
    cmd(CMD_DEVICE_ERASE, 16'h0);
    rdck(SEL_COMMAND_DATA, 8'h00);
    // Broken pair, then the second code twice, then the true pair
    wr(SEL_UNLOCK_CONTROL, UNLOCK_FIRST);
    wr(SEL_UNLOCK_CONTROL, 8'h05);
    wr(SEL_UNLOCK_CONTROL, UNLOCK_SECOND);
    wr(SEL_UNLOCK_CONTROL, UNLOCK_SECOND);
    repeat (8) @(posedge core_clk);
    check(programEnabled, 16'h0);
    wr(SEL_UNLOCK_CONTROL, UNLOCK_FIRST);
    wr(SEL_UNLOCK_CONTROL, UNLOCK_SECOND);
    repeat (8) @(posedge core_clk);
    check({programEnabled, coreHalt}, 16'h3);
    rdck(SEL_UNLOCK_CONTROL, UNLOCK_SECOND);
    host.frame(INS_SELECT_READ, 8'h00, rd);
    check({8'h00, rd}, {8'h00, SEL_UNLOCK_CONTROL});
    // Bad code first: it must leave the command phase in place
    for (int i = 0; i < 5; i++) begin
      cmd(codes[i], hits[i]);
      if (i > 0) cmd(8'hA5, 16'h01A5);
      @(posedge core_clk) #1 flashDone = 1'b1;
      @(posedge core_clk) #1 flashDone = 1'b0;
    end
    @(posedge core_clk) #1 flashReadData = 8'hC3;
    flashReadValid = 1'b1;
    @(posedge core_clk) #1 flashReadValid = 1'b0;
    rdck(SEL_COMMAND_DATA, 8'hC3);
    check({programEnabled, coreHalt}, 16'h3);
    // Reset mid-run; a frame gives the link side its edges
    @(posedge core_clk) #1 nrst = 1'b0;
    host.frame(INS_SELECT_READ, 8'h00, rd);
    check({programEnabled, coreHalt, flashReq}, 16'h0);
    @(posedge core_clk) #1 nrst = 1'b1;
    rdck(SEL_UNLOCK_CONTROL, UNLOCK_CONTROL_RESET);
    tally_and_finish();
  end
endmodule : dpf_debug_port_tb

// >>> tb/dpf_host_model.sv
`timescale 1ns/1ns
// Host adapter; the link clock only runs inside frames
module dpf_host_model (
  input wire logic lineLvl,
  output logic linkClk,
  output logic hostBit
);
  initial begin
    linkClk = 1'b0;
    hostBit = 1'b1; // Idle line high
  end
  // Start bit, two instruction bits, eight data bits LSB first
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [10:0] seq;
    seq = {wd, ins, 1'b0};
    rd = 8'h00;
    for (int i = 0; i < 11; i++) begin
      // Released during read data, so the pull-up shows
      hostBit = (i > 2 && !ins[0]) ? 1'b1 : seq[i];
      #3 linkClk = 1'b1;
      #3 linkClk = 1'b0;
      if (i > 1 && i < 10 && !ins[0]) rd[i-2] = lineLvl;
    end
    // Idle gap, so back-to-back frames never write the line twice in one step
    hostBit = 1'b1;
    #3;
  endtask : frame
endmodule : dpf_host_model
